// ==== include/ts_regs.svh ====
/*
 Register offsets, field positions, reset values and timing figures of the
 temperature sensor register map. Assumes it is included by its bare name.
*/
`ifndef TS_REGS_SVH
`define TS_REGS_SVH

// Register selection codes
`define TS_SEL_TEMP 2'h0
`define TS_SEL_CFG 2'h1
`define TS_SEL_LOW 2'h2
`define TS_SEL_HIGH 2'h3
`define TS_SEL_RST 2'h0

// Configuration first byte field positions
`define TS_CFG_ONESHOT_BIT 7
`define TS_CFG_FAULT_LSB 3
`define TS_CFG_POL_BIT 2
`define TS_CFG_TM_BIT 1
`define TS_CFG_SD_BIT 0
// Configuration second byte field positions
`define TS_CFG_RATE_LSB 6
`define TS_CFG_EM_BIT 4

// Reset values
`define TS_RESOLUTION 2'h3
`define TS_RATE_RST 2'h2
`define TS_ALERT_LEVEL_RST 1'h1
`define TS_LOW_RST 16'h4B00
`define TS_HIGH_RST 16'h5000

// Conversion periods in ms and the clock rate in kHz
`define TS_RATE_00_MS 4000
`define TS_RATE_01_MS 1000
`define TS_RATE_10_MS 250
`define TS_RATE_11_MS 125
`define TS_CLK_KHZ 100000

`endif

// ==== include/ts_pkg.sv ====
/*
 Types shared by the temperature sensor register map.
 Assumes ts_regs.svh is available for constants.
*/
package ts_pkg;

   // Serial link byte engine states
   typedef enum logic [2:0] {
      LK_IDLE,
      LK_ADDR,
      LK_AACK,
      LK_WR,
      LK_WACK,
      LK_RD,
      LK_RACK
   } ts_link_e;

   // Conversion scheduler states
   typedef enum logic [1:0] {
      CV_BOOT,
      CV_CONV,
      CV_WAIT,
      CV_SLEEP
   } ts_conv_e;

   // Configuration fields as seen by the rest of the sensor, all writable except alert_level
   typedef struct packed {
      logic [1:0] fault_count_select;
      logic alert_polarity;
      logic thermostat_select;
      logic shutdown_request;
      logic [1:0] conversion_rate_select;
      logic alert_level;
      logic extended_format;
   } ts_cfg_s;

endpackage

// ==== src/ts_sync.sv ====
/*
 Two flip-flop synchroniser for a group of level inputs.
 Assumes each bit changes slowly compared with the destination clock.
*/
`timescale 1ns/1ps
`default_nettype none

module ts_sync #(
   parameter int unsigned W = 2
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] meta;

   // Resets high, the idle level of an open-drain bus
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta <= '1;
         q_o <= '1;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end

endmodule

`default_nettype wire

// ==== src/ts_regmap.sv ====
/*
 Register map of a two-wire temperature sensor: selection byte, result,
 configuration and limit registers, plus the conversion scheduler.
 Assumes an open-drain bus resolved outside and a converter that answers a
 start pulse with one conv_valid_i pulse in the mclk_i domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ts_regs.svh"

// What this block does
// - Eight-bit selection byte; its two low bits pick the register.
// - Selection resets to temperature; 01 config, 10 low, 11 high limit.
// - Result register is read-only, holds latest conversion, 12 or 13 bits.
// - Result goes out high byte first; host may stop after one byte.
// - Temperature is left-justified two's complement, 0.0625 degrees per count.
// - After reset the result reads zero until the first conversion ends.
// - Low bit of second result byte shows the extended format flag.
// - Result bits without temperature or format meaning read zero.
// - Configuration is 16 bits read/write, sent high bit first.
// - Every writable register updates byte by byte as bytes arrive.
// - Configuration field layout across both bytes, low nibble zero.
// - Reset sets resolution, upper rate bit and alert level; clears others.
// - Extended flag switches result between 12 and 13 bits; limits keep all 16 bits as written.
// - Rate bits pick 0.25, 1, 4 or 8 conversions per second.
// - Shutdown finishes the running conversion then stops; else continuous.
// - One-shot write in shutdown runs one conversion; flag reads done.
// - Resolution bits are read-only and fixed at 11.
module ts_regmap import ts_pkg::*; #(
   parameter logic [6:0] DEV_ADDR = 7'h2A, // Arbitrary bus address
   parameter int unsigned PER_00_CYC = `TS_RATE_00_MS * `TS_CLK_KHZ,
   parameter int unsigned PER_01_CYC = `TS_RATE_01_MS * `TS_CLK_KHZ,
   parameter int unsigned PER_10_CYC = `TS_RATE_10_MS * `TS_CLK_KHZ,
   parameter int unsigned PER_11_CYC = `TS_RATE_11_MS * `TS_CLK_KHZ
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // Two-wire bus pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // Converter handshake
   output logic conv_start_o,
   input wire logic conv_valid_i,
   input wire logic [12:0] conv_temp_i,
   // Settings for alert and analog logic
   output ts_cfg_s cfg_o,
   output logic [15:0] lower_limit_o,
   output logic [15:0] upper_limit_o
);

   // Refuse periods too short for the scheduler
   if (PER_11_CYC < 2 || PER_10_CYC < 2 || PER_01_CYC < 2 || PER_00_CYC < 2) begin : g_chk
      $error("conversion periods must be at least two cycles");
   end

   logic [1:0] pin_s;
   logic scl_d, sda_d;
   ts_link_e lst;
   logic [7:0] shreg;
   logic [2:0] bitcnt;
   logic got8, is_rd, ack_ok, rd_idx;
   logic [1:0] wr_idx;
   logic [1:0] reg_sel;
   ts_conv_e cst;
   logic [31:0] cnt;
   logic [12:0] temp_raw;
   logic os_flag, os_run;
   logic scl_s, sda_s, scl_rise, scl_fall, start_c, stop_c;
   logic wr_evt, rd_load, os_req;
   logic [7:0] next_rd_byte;
   logic [31:0] period;

   function automatic logic [15:0] fmt_temp(input logic [12:0] t, input logic em);
      logic [11:0] c;
      c = t[11:0];
      if (t[12] && t[11] == 1'b0) c = 12'h800;
      if (!t[12] && t[11]) c = 12'h7FF;
      fmt_temp = em ? {t, 3'h1} : {c, 4'h0};
   endfunction

   // Selects the byte a read returns
   function automatic logic [7:0] read_byte(input logic [1:0] sel, input logic idx);
      logic [15:0] w;
      case (sel)
         `TS_SEL_TEMP: w = fmt_temp(temp_raw, cfg_o.extended_format);
         `TS_SEL_CFG: w = {os_flag, `TS_RESOLUTION, cfg_o.fault_count_select, cfg_o.alert_polarity,
            cfg_o.thermostat_select, cfg_o.shutdown_request, cfg_o.conversion_rate_select,
            cfg_o.alert_level, cfg_o.extended_format, 4'h0};
         `TS_SEL_LOW: w = lower_limit_o;
         default: w = upper_limit_o;
      endcase
      read_byte = idx ? w[7:0] : w[15:8];
   endfunction

   // Bus pins come from another clock domain
   ts_sync #(.W(2)) u_sync (
      .clk_i(mclk_i),
      .rst_i(sys_rst_i),
      .d_i({scl_i, sda_i}),
      .q_o(pin_s)
   );
   assign scl_s = pin_s[1];
   assign sda_s = pin_s[0];

   // Delayed copies for edge finding
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   // Bus events; START and STOP only while the clock is high
   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;
   assign start_c = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_c = scl_s & scl_d & ~sda_d & sda_s;
   assign wr_evt = scl_fall && lst == LK_WR && got8;
   assign rd_load = scl_fall && ((lst == LK_AACK && is_rd) || (lst == LK_RACK && ack_ok));
   // A process, not an assign, so it follows every register the function reads
   always_comb begin
      next_rd_byte = read_byte(reg_sel, rd_idx);
   end

   // Byte engine; sda only moves while scl is low, so it never fakes START or STOP
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         lst <= LK_IDLE;
         shreg <= 8'h00;
         bitcnt <= 3'h0;
         got8 <= 1'b0;
         is_rd <= 1'b0;
         ack_ok <= 1'b0;
         rd_idx <= 1'b0;
         wr_idx <= 2'h0;
         sda_oe_o <= 1'b0;
         sda_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
         if (start_c) begin
            lst <= LK_ADDR;
            bitcnt <= 3'h0;
            got8 <= 1'b0;
            wr_idx <= 2'h0;
            rd_idx <= 1'b0;
            sda_oe_o <= 1'b0;
         end else if (stop_c) begin
            lst <= LK_IDLE;
            sda_oe_o <= 1'b0;
         end else begin
            case (lst)
               LK_ADDR, LK_WR: begin
                  if (scl_rise) begin
                     shreg <= {shreg[6:0], sda_s};
                     bitcnt <= bitcnt + 3'h1;
                     got8 <= (bitcnt == 3'h7);
                  end else if (scl_fall && got8) begin
                     got8 <= 1'b0;
                     if (lst == LK_WR) begin
                        sda_oe_o <= 1'b1;
                        lst <= LK_WACK;
                        if (wr_idx != 2'h3) wr_idx <= wr_idx + 2'h1;
                     end else if (shreg[7:1] == DEV_ADDR) begin
                        is_rd <= shreg[0];
                        sda_oe_o <= 1'b1;
                        lst <= LK_AACK;
                     end else begin
                        lst <= LK_IDLE;
                     end
                  end
               end
               LK_WACK: begin
                  if (scl_fall) begin
                     sda_oe_o <= 1'b0;
                     lst <= LK_WR;
                  end
               end
               LK_AACK, LK_RACK: begin
                  if (scl_rise) ack_ok <= ~sda_s;
                  // high byte first, ends on NACK
                  if (rd_load) begin
                     shreg <= next_rd_byte;
                     sda_oe_o <= ~next_rd_byte[7];
                     rd_idx <= ~rd_idx;
                     bitcnt <= 3'h0;
                     lst <= LK_RD;
                  end else if (scl_fall) begin
                     sda_oe_o <= 1'b0;
                     lst <= (lst == LK_AACK) ? LK_WR : LK_IDLE;
                  end
               end
               LK_RD: begin
                  if (scl_rise) begin
                     bitcnt <= bitcnt + 3'h1;
                     got8 <= (bitcnt == 3'h7);
                  end else if (scl_fall) begin
                     if (got8) begin
                        got8 <= 1'b0;
                        sda_oe_o <= 1'b0;
                        lst <= LK_RACK;
                     end else begin
                        shreg <= {shreg[6:0], 1'b0};
                        sda_oe_o <= ~shreg[6];
                     end
                  end
               end
               default: lst <= LK_IDLE;
            endcase
         end
      end
   end

   // Register writes land per byte; upper selection bits are the host's to keep zero
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reg_sel <= `TS_SEL_RST;
         cfg_o <= '{fault_count_select: 2'h0, alert_polarity: 1'b0, thermostat_select: 1'b0,
            shutdown_request: 1'b0, conversion_rate_select: `TS_RATE_RST,
            alert_level: `TS_ALERT_LEVEL_RST, extended_format: 1'b0};
         lower_limit_o <= `TS_LOW_RST;
         upper_limit_o <= `TS_HIGH_RST;
      end else if (wr_evt) begin
         // selection byte, takes effect for later reads
         if (wr_idx == 2'h0) begin
            reg_sel <= shreg[1:0];
         end else if (wr_idx != 2'h3) begin
            // each byte stored on arrival; result not writable
            case (reg_sel)
               `TS_SEL_CFG: begin
                  if (wr_idx == 2'h1) begin
                     cfg_o.fault_count_select <= shreg[`TS_CFG_FAULT_LSB+:2];
                     cfg_o.alert_polarity <= shreg[`TS_CFG_POL_BIT];
                     cfg_o.thermostat_select <= shreg[`TS_CFG_TM_BIT];
                     cfg_o.shutdown_request <= shreg[`TS_CFG_SD_BIT];
                  end else begin
                     cfg_o.conversion_rate_select <= shreg[`TS_CFG_RATE_LSB+:2];
                     cfg_o.extended_format <= shreg[`TS_CFG_EM_BIT];
                  end
               end
               `TS_SEL_LOW: begin
                  if (wr_idx == 2'h1) lower_limit_o[15:8] <= shreg;
                  else lower_limit_o[7:0] <= shreg;
               end
               `TS_SEL_HIGH: begin
                  if (wr_idx == 2'h1) upper_limit_o[15:8] <= shreg;
                  else upper_limit_o[7:0] <= shreg;
               end
               default: ;
            endcase
         end
      end
   end

   always_comb begin
      case (cfg_o.conversion_rate_select)
         2'h0: period = PER_00_CYC;
         2'h1: period = PER_01_CYC;
         2'h2: period = PER_10_CYC;
         default: period = PER_11_CYC;
      endcase
   end

   // one-shot request only counts while asleep
   assign os_req = wr_evt && wr_idx == 2'h1 && reg_sel == `TS_SEL_CFG && shreg[`TS_CFG_ONESHOT_BIT]
      && cst == CV_SLEEP;

   // Conversion scheduler; the period runs from one start to the next
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cst <= CV_BOOT;
         cnt <= 32'h0;
         conv_start_o <= 1'b0;
         temp_raw <= 13'h0000;
         os_flag <= 1'b0;
         os_run <= 1'b0;
      end else begin
         conv_start_o <= 1'b0;
         case (cst)
            CV_BOOT: begin
               conv_start_o <= 1'b1;
               cnt <= 32'h0;
               cst <= CV_CONV;
            end
            CV_CONV: begin
               cnt <= cnt + 32'h1;
               if (conv_valid_i) begin
                  // latest result kept in full; formatted on read
                  temp_raw <= conv_temp_i;
                  os_run <= 1'b0;
                  if (os_run) os_flag <= 1'b1;
                  cst <= cfg_o.shutdown_request ? CV_SLEEP : CV_WAIT;
               end
            end
            CV_WAIT: begin
               cnt <= cnt + 32'h1;
               if (cfg_o.shutdown_request) begin
                  cst <= CV_SLEEP;
               end else if (cnt >= period - 32'h1) begin
                  conv_start_o <= 1'b1;
                  cnt <= 32'h0;
                  cst <= CV_CONV;
               end
            end
            CV_SLEEP: begin
               if (os_req || !cfg_o.shutdown_request) begin
                  conv_start_o <= 1'b1;
                  cnt <= 32'h0;
                  cst <= CV_CONV;
                  os_run <= os_req;
                  if (os_req) os_flag <= 1'b0;
               end
            end
            default: cst <= CV_BOOT;
         endcase
      end
   end

   a_sel_update: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      wr_evt && wr_idx == 2'h0 |=> reg_sel == $past(shreg[1:0])) else $error("selection not updated");
   a_temp_readonly: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      wr_evt && reg_sel == `TS_SEL_TEMP && !conv_valid_i |=> $stable(temp_raw))
      else $error("result changed by a write");
   a_res_fixed: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      reg_sel == `TS_SEL_CFG && !rd_idx |-> next_rd_byte[6:5] == 2'h3) else $error("resolution not 11");
   a_format_flag: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      reg_sel == `TS_SEL_TEMP && rd_idx |-> next_rd_byte[0] == cfg_o.extended_format)
      else $error("format flag wrong");
   a_unused_zero: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      reg_sel == `TS_SEL_TEMP && rd_idx |-> next_rd_byte[2:1] == 2'h0 && (cfg_o.extended_format
      || next_rd_byte[3] == 1'b0)) else $error("unused result bits set");
   a_result_capture: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      cst == CV_CONV && conv_valid_i |=> temp_raw == $past(conv_temp_i)) else $error("result not taken");
   a_cfg_bytewise: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      wr_evt && wr_idx == 2'h1 && reg_sel == `TS_SEL_CFG |=> cfg_o.shutdown_request == $past(shreg[0]))
      else $error("config byte not stored");
   a_oneshot_start: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      os_req |=> cst == CV_CONV && conv_start_o && !os_flag) else $error("one-shot not started");
   a_shutdown_stop: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      cst == CV_CONV && conv_valid_i && cfg_o.shutdown_request |=> cst == CV_SLEEP ##1 !conv_start_o)
      else $error("no shutdown after conversion");

endmodule

`default_nettype wire

// ==== tb/ts_host_model.sv ====
/*
 Behavioural two-wire bus host that drives the sensor register map.
 Assumes the bench resolves the open-drain data wire with a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none

module ts_host_model #(
   parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary bus address
) (
   // Clock
   input wire logic mclk_i,
   // Bus pins
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_low_o
);
   // Bus released; the link clock stands high between frames
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end

   // Wait on system clock edges
   task automatic hold(input int n);
      repeat (n) @(posedge mclk_i);
   endtask

   // One bit slot; data moves a cycle after the fall so it never races the edge
   task automatic bit_slot(input logic b, output logic s);
      hold(1);
      sda_low_o <= ~b;
      hold(3);
      scl_o <= 1'b1;
      hold(4);
      s = sda_i;
      scl_o <= 1'b0;
   endtask

   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(b[i], s);
      end
      bit_slot(1'b1, s);
      ack = ~s;
   endtask

   // Receive one byte, then acknowledge or end the read
   task automatic recv_byte(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(1'b1, s);
         b[i] = s;
      end
      bit_slot(last, s);
   endtask

   // Start condition entered with the link clock high, stop condition with it low
   task automatic start_cond();
      hold(4);
      sda_low_o <= 1'b1;
      hold(4);
      scl_o <= 1'b0;
   endtask

   task automatic stop_cond();
      hold(1);
      sda_low_o <= 1'b1;
      hold(3);
      scl_o <= 1'b1;
      hold(4);
      sda_low_o <= 1'b0;
      hold(4);
   endtask

   // Write frame: selection byte, then nb data bytes high byte first
   task automatic write_frame(input logic [1:0] sel, input logic [15:0] v, input int nb, output int acks);
      logic a;
      start_cond();
      send_byte({DEV_ADDR, 1'b0}, a);
      acks = int'(a);
      send_byte({6'h00, sel}, a);
      acks += int'(a);
      for (int i = 0; i < nb; i++) begin
         send_byte(i == 0 ? v[15:8] : v[7:0], a);
         acks += int'(a);
      end
      stop_cond();
   endtask

   // Read frame of nb bytes, last byte not acknowledged
   task automatic read_frame(input int nb, output logic [15:0] v);
      logic a;
      logic [7:0] b;
      v = 16'h0000;
      start_cond();
      send_byte({DEV_ADDR, 1'b1}, a);
      for (int i = 0; i < nb; i++) begin
         recv_byte(i == nb - 1, b);
         v = {v[7:0], b};
      end
      stop_cond();
   endtask
endmodule

`default_nettype wire

// ==== tb/ts_regmap_tb.sv ====
/*
 Self-checking bench of the sensor register map with host model and converter stub.
 Assumes shortened conversion periods, set below and handed to the design.
*/
`timescale 1ns/1ps
`default_nettype none

module ts_regmap_tb import ts_pkg::*; ;
   localparam int P00 = 200;
   localparam int P01 = 100;
   localparam int P10 = 50;
   localparam int P11 = 25;
   localparam logic [6:0] ADDR = 7'h2A; // Arbitrary bus address
   logic mclk_i;
   logic sys_rst_i;
   logic scl;
   logic host_low;
   logic sda_w;
   logic sda_oe;
   logic conv_start;
   logic conv_valid = 1'b0;
   logic conv_en;
   logic sda_val;
   logic [12:0] conv_temp;
   logic [15:0] lo;
   logic [15:0] hi;
   logic [15:0] d;
   ts_cfg_s cfg;
   int n_errors;
   int checks;
   int n_starts = 0;
   int cv_cnt = 0;
   int n;
   int a;
   logic [12:0] t_in [4] = '{13'h0960, 13'h1C90, 13'h0960, 13'h1C90};
   logic [15:0] t_exp [4] = '{16'h4B01, 16'hE481, 16'h7FF0, 16'hC900};
   // Configuration per step: rates 01, 11, 01, 00 with extended format on, on, off, off
   logic [15:0] t_cfg [4] = '{16'h1E50, 16'h1ED0, 16'h1E40, 16'h1E00};
   int t_per [4] = '{P01, P11, P01, P00};

   // Open-drain wire with pull-up: low while either party pulls
   assign sda_w = ~(host_low | sda_oe);

   ts_regmap #(.DEV_ADDR(ADDR), .PER_00_CYC(P00), .PER_01_CYC(P01), .PER_10_CYC(P10), .PER_11_CYC(P11)) dut (
      .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_val), .sda_oe_o(sda_oe),
      .conv_start_o(conv_start), .conv_valid_i(conv_valid), .conv_temp_i(conv_temp),
      .cfg_o(cfg), .lower_limit_o(lo), .upper_limit_o(hi));

   ts_host_model #(.DEV_ADDR(ADDR)) host (.mclk_i(mclk_i), .sda_i(sda_w), .scl_o(scl), .sda_low_o(host_low));

   // System clock, 100 MHz
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end

   // Converter stub: result six cycles after a start; the last step waits until enabled
   always @(posedge mclk_i) begin
      conv_valid <= 1'b0;
      if (conv_start === 1'b1) begin
         n_starts <= n_starts + 1;
         cv_cnt <= 6;
      end else if (cv_cnt > 1 || (cv_cnt == 1 && conv_en)) begin
         cv_cnt <= cv_cnt - 1;
         conv_valid <= (cv_cnt == 1);
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [1:0] sel, input logic [15:0] v, input int nb);
      host.write_frame(sel, v, nb, a);
   endtask

   task automatic rd(input int nb);
      host.read_frame(nb, d);
   endtask

   // Cycles from one start pulse to the next, bounded so a stall cannot hang
   task automatic gap(output int c);
      int k;
      k = 0;
      while (conv_start !== 1'b1 && k < 2000) begin
         @(posedge mclk_i);
         k++;
      end
      c = 0;
      do begin
         @(posedge mclk_i);
         c++;
      end while (conv_start !== 1'b1 && c < 2000);
   endtask

   task automatic conclude();
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      sys_rst_i = 1'b1;
      conv_en = 1'b0;
      conv_temp = 13'h0190;
      n_errors = 0;
      checks = 0;
      repeat (3) @(posedge mclk_i);
      chk({7'h00, cfg}, 16'h000A);
      chk(lo, 16'h4B00);
      chk(hi, 16'h5000);
      sys_rst_i <= 1'b0;
      // Converter held back, so a result taken too early would show as non-zero
      rd(2);
      chk(d, 16'h0000);
      chk(16'(sda_val), 16'h0000);
      conv_en <= 1'b1;
      gap(n);
      chk(16'(n), 16'(P10));
      for (int i = 1; i < 4; i++) begin
         wr(2'(i), 16'h0000, 0);
         rd(2);
         chk(d, i == 1 ? 16'h60A0 : (i == 2 ? 16'h4B00 : 16'h5000));
      end
      wr(2'h2, 16'hC970, 2);
      chk(16'(a), 16'h0004);
      wr(2'h2, 16'h1900, 1);
      chk(lo, 16'h1970);
      rd(2);
      chk(d, 16'h1970);
      wr(2'h1, 16'h1E50, 2);
      chk({7'h00, cfg}, 16'h01E7);
      rd(2);
      chk(d, 16'h7E70);
      gap(n);
      gap(n);
      chk(16'(n), 16'(P01));
      conv_en <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         wr(2'h1, t_cfg[i], 2);
         conv_temp <= t_in[i];
         gap(n);
         chk(16'(n), 16'(t_per[i]));
         repeat (10) @(posedge mclk_i);
         wr(2'h0, 16'h0000, 0);
         rd(2);
         chk(d, t_exp[i]);
      end
      wr(2'h0, 16'hFFFF, 2);
      rd(1);
      chk(d, 16'h00C9);
      rd(2);
      chk(d, 16'hC900);
      wr(2'h1, 16'h0100, 1);
      chk({15'h0000, cfg.shutdown_request}, 16'h0001);
      repeat (20) @(posedge mclk_i);
      n = n_starts;
      repeat (3 * P01) @(posedge mclk_i);
      chk(16'(n_starts - n), 16'h0000);
      wr(2'h1, 16'h8100, 1);
      repeat (20) @(posedge mclk_i);
      chk(16'(n_starts - n), 16'h0001);
      rd(1);
      chk(d, 16'h00E1);
      conclude();
   end

   // Watchdog, well above the roughly 10k cycles the sequence needs
   initial begin
      repeat (60000) @(posedge mclk_i);
      n_errors++;
      conclude();
   end
endmodule

`default_nettype wire
